/* rtl/plc_cfg.svh */
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH

// Register byte offsets on the Avalon-MM slave.
`define PLC_ADDR_CTRL      4'h0
`define PLC_ADDR_STATUS    4'h4
`define PLC_ADDR_CNT       4'h8
// Control register fields.
`define PLC_CTRL_LOOP_BIT  0
`define PLC_CTRL_MGMT_BIT  1
`define PLC_CTRL_RST       32'h0000_0002
// Status register fields.
`define PLC_ST_ACTIVE_BIT  0
`define PLC_ST_TBI_BIT     1
`define PLC_ST_RCLK_BIT    2
`define PLC_ST_EMPTY_BIT   3
`define PLC_ST_FULL_BIT    4
// Unmapped reads return this value.
`define PLC_BAD_READ       32'hDEAD_0000
// Idle code groups: K28.5 then D16.2, both running-disparity choices left to the encoder.
`define PLC_K28_5          8'hBC
`define PLC_D16_2          8'h50
`define PLC_FIFO_DEPTH     16
`define PLC_FIFO_WIDTH     9
`define PLC_LOOP_SEL_OFF   2'h0

`endif

/* rtl/plc_pkg.sv */
package plc_pkg;
  // A code group before the serialiser: control flag plus octet.
  typedef struct packed {
    logic       is_k;
    logic [7:0] octet;
  } plc_cg_t;

  typedef enum logic {
    PLC_IDLE_K,
    PLC_IDLE_D
  } plc_idle_t;
endpackage

/* rtl/plc_fifo.sv */
`timescale 1ns/100ps
module plc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Level flags
  output logic                  full,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } plc_fifo_st_t;

  plc_fifo_st_t   st_r;
  plc_fifo_st_t   st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign full      = (st_r.cnt == (AW+1)'(DEPTH));
  assign empty     = (st_r.cnt == '0);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[st_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[st_r.wp] <= in_data;
    end
  end
endmodule

/* rtl/plc_loopback.sv */
`timescale 1ns/100ps
`include "plc_cfg.svh"
// How it works
// - Loopback is switched by management register or static configuration input.
// - Ten-bit interface build has no internal transmit-to-receive path.
// - Ten-bit build: loopback drives the serialiser wrap request high.
// - Transceiver build: transmit code groups feed receive path just before transceiver.
// - Transceiver build: line gets continuous Idle code groups during loopback.
// - Transceiver loop select output is always driven zero on both bits.
// - Loopback is unavailable when receive clock comes from recovered clock.
module plc_loopback #(
  parameter bit TBI_BUILD = 1'b0
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Avalon-MM register slave
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // Static configuration
  input  wire logic                cfg_loopback,
  input  wire logic                receive_clock_source_select,
  // Transmit code groups from the encoder
  input  wire logic                tx_valid,
  output logic                     tx_ready,
  input  wire plc_pkg::plc_cg_t    tx_cg,
  // Code groups to the transceiver
  output plc_pkg::plc_cg_t         line_tx_cg,
  output logic [1:0]               xcvr_loop_sel,
  // Code groups from the transceiver
  input  wire plc_pkg::plc_cg_t    line_rx_cg,
  // Code groups to the receive path
  output logic                     rx_valid,
  input  wire logic                rx_ready,
  output plc_pkg::plc_cg_t         rx_cg,
  // Serialiser wrap request
  output logic                     wrap_req
);

  typedef struct packed {
    logic               loop_en;
    logic               use_mgmt;
    logic               ack;
    logic [31:0]        rdata;
    plc_pkg::plc_idle_t idle;
    plc_pkg::plc_cg_t   line;
    logic               wrap;
    logic [15:0]        loop_cnt;
  } plc_st_t;

  plc_st_t          st_r;
  plc_st_t          st_nxt;
  logic             loop_req;
  logic             loop_act;
  logic             f_full;
  logic             f_empty;
  logic             f_out_valid;
  plc_pkg::plc_cg_t f_out;
  logic             f_in_valid;
  logic             f_out_ready;
  logic             sel_ctrl;
  logic             sel_stat;
  logic             sel_cnt;

  // Reset value of the control word; only its mode bit is loaded from it, loop_en resets to zero.
  localparam logic [31:0] CTRL_RST = `PLC_CTRL_RST;

  assign loop_req = st_r.use_mgmt ? st_r.loop_en : cfg_loopback;
  assign loop_act = loop_req && !receive_clock_source_select;

  assign f_in_valid  = tx_valid && loop_act && !TBI_BUILD;
  assign f_out_ready = rx_ready;

  // Outside loopback the encoder is never stalled; the line takes every group.
  assign tx_ready = (loop_act && !TBI_BUILD) ? !f_full : 1'b1;

  plc_fifo #(
    .WIDTH (`PLC_FIFO_WIDTH),
    .DEPTH (`PLC_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (f_in_valid),
    .in_ready  (),
    .in_data   (tx_cg),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out),
    .full      (f_full),
    .empty     (f_empty)
  );

  assign rx_valid = (loop_act && !TBI_BUILD) ? f_out_valid : 1'b1;
  assign rx_cg    = (loop_act && !TBI_BUILD) ? f_out : line_rx_cg;

  assign xcvr_loop_sel = `PLC_LOOP_SEL_OFF;
  assign line_tx_cg    = st_r.line;
  assign wrap_req      = st_r.wrap;

  assign sel_ctrl = (avs_address == `PLC_ADDR_CTRL);
  assign sel_stat = (avs_address == `PLC_ADDR_STATUS);
  assign sel_cnt  = (avs_address == `PLC_ADDR_CNT);

  // Every access takes exactly one wait cycle, so read data can come from a flop.
  assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
  assign avs_readdata    = st_r.rdata;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = (avs_read || avs_write) && !st_r.ack;
    // A write lands at the edge where waitrequest is seen low, as the master expects.
    if (avs_write && st_r.ack && sel_ctrl && avs_byteenable[0]) begin
      st_nxt.loop_en  = avs_writedata[`PLC_CTRL_LOOP_BIT];
      st_nxt.use_mgmt = avs_writedata[`PLC_CTRL_MGMT_BIT];
    end
    if (avs_read && !st_r.ack) begin
      st_nxt.rdata = 32'h0000_0000;
      if (sel_ctrl) begin
        st_nxt.rdata[`PLC_CTRL_LOOP_BIT] = st_r.loop_en;
        st_nxt.rdata[`PLC_CTRL_MGMT_BIT] = st_r.use_mgmt;
      end else if (sel_stat) begin
        st_nxt.rdata[`PLC_ST_ACTIVE_BIT] = loop_act;
        st_nxt.rdata[`PLC_ST_TBI_BIT]    = TBI_BUILD;
        st_nxt.rdata[`PLC_ST_RCLK_BIT]   = receive_clock_source_select;
        st_nxt.rdata[`PLC_ST_EMPTY_BIT]  = f_empty;
        st_nxt.rdata[`PLC_ST_FULL_BIT]   = f_full;
      end else if (sel_cnt) begin
        st_nxt.rdata[15:0] = st_r.loop_cnt;
      end else begin
        st_nxt.rdata = `PLC_BAD_READ;
      end
    end
    if (f_in_valid && !f_full) begin
      st_nxt.loop_cnt = st_r.loop_cnt + 16'h0001;
    end
    st_nxt.wrap = TBI_BUILD && loop_act;
    if (loop_act && !TBI_BUILD) begin
      st_nxt.line.is_k  = (st_r.idle == plc_pkg::PLC_IDLE_K);
      st_nxt.line.octet = (st_r.idle == plc_pkg::PLC_IDLE_K) ? `PLC_K28_5 : `PLC_D16_2;
      st_nxt.idle       = (st_r.idle == plc_pkg::PLC_IDLE_K) ? plc_pkg::PLC_IDLE_D
                                                               : plc_pkg::PLC_IDLE_K;
    end else begin
      st_nxt.line = tx_valid ? tx_cg : '0;
      st_nxt.idle = plc_pkg::PLC_IDLE_K;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r          <= '0;
      st_r.use_mgmt <= CTRL_RST[`PLC_CTRL_MGMT_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  property p_wrap_on;
    @(posedge mclk) disable iff (rst)
      (TBI_BUILD && loop_act) |=> wrap_req;
  endproperty
  a_wrap_on: assert property (p_wrap_on) else $error("wrap request not raised");

  property p_wrap_off;
    @(posedge mclk) disable iff (rst)
      !loop_act |=> !wrap_req;
  endproperty
  a_wrap_off: assert property (p_wrap_off) else $error("wrap request high while off");

  property p_no_path;
    @(posedge mclk) disable iff (rst)
      TBI_BUILD |-> (rx_cg == line_rx_cg && !f_in_valid);
  endproperty
  a_no_path: assert property (p_no_path) else $error("internal path in ten-bit build");

  property p_sel_zero;
    @(posedge mclk) disable iff (rst)
      xcvr_loop_sel == 2'h0;
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("loop select not zero");

  sequence s_idle_kd;
    (line_tx_cg.is_k && line_tx_cg.octet == `PLC_K28_5) ##1
      (!line_tx_cg.is_k && line_tx_cg.octet == `PLC_D16_2);
  endsequence

  sequence s_idle_dk;
    (!line_tx_cg.is_k && line_tx_cg.octet == `PLC_D16_2) ##1
      (line_tx_cg.is_k && line_tx_cg.octet == `PLC_K28_5);
  endsequence

  // Two active cycles make both the current and the next line group idle ones.
  property p_idle;
    @(posedge mclk) disable iff (rst)
      (!TBI_BUILD && loop_act) [*2] |-> (s_idle_kd or s_idle_dk);
  endproperty
  a_idle: assert property (p_idle) else $error("line not sending idle in loopback");

  property p_route;
    @(posedge mclk) disable iff (rst)
      (!TBI_BUILD && loop_act && f_out_valid) |-> (rx_cg == f_out && rx_valid);
  endproperty
  a_route: assert property (p_route) else $error("looped data not on receive path");

  property p_rclk;
    @(posedge mclk) disable iff (rst)
      receive_clock_source_select |-> (rx_cg == line_rx_cg && !f_in_valid) ##1 !wrap_req;
  endproperty
  a_rclk: assert property (p_rclk) else $error("loopback active on recovered clock");

  property p_mode;
    @(posedge mclk) disable iff (rst)
      (!st_r.use_mgmt && !receive_clock_source_select) |-> (loop_act == cfg_loopback);
  endproperty
  a_mode: assert property (p_mode) else $error("static vector ignored");

  property p_ack;
    @(posedge mclk) disable iff (rst)
      ($rose(avs_read) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");

  property p_one_wait;
    @(posedge mclk) disable iff (rst)
      ((avs_read || avs_write) && !st_r.ack) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");

  property p_rd_hold;
    @(posedge mclk) disable iff (rst)
      !(avs_read && !st_r.ack) |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

  property p_lane_guard;
    @(posedge mclk) disable iff (rst)
      (avs_write && !avs_byteenable[0]) |=> ($stable(st_r.loop_en) && $stable(st_r.use_mgmt));
  endproperty
  a_lane_guard: assert property (p_lane_guard) else $error("control changed by masked write");

  property p_idle_start;
    @(posedge mclk) disable iff (rst)
      ($rose(loop_act) && !TBI_BUILD) |=> (line_tx_cg.is_k && line_tx_cg.octet == `PLC_K28_5);
  endproperty
  a_idle_start: assert property (p_idle_start) else $error("idle did not start with K");

  property p_pass_line;
    @(posedge mclk) disable iff (rst)
      (!(loop_act && !TBI_BUILD) && tx_valid) |=> (line_tx_cg == $past(tx_cg));
  endproperty
  a_pass_line: assert property (p_pass_line) else $error("line lost transmit group");

  property p_pass_quiet;
    @(posedge mclk) disable iff (rst)
      (!(loop_act && !TBI_BUILD) && !tx_valid) |=> (line_tx_cg == 9'h000);
  endproperty
  a_pass_quiet: assert property (p_pass_quiet) else $error("line not quiet without data");

  property p_no_stall;
    @(posedge mclk) disable iff (rst)
      !(loop_act && !TBI_BUILD) |-> tx_ready;
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("encoder stalled outside loopback");

  property p_rx_line;
    @(posedge mclk) disable iff (rst)
      !(loop_act && !TBI_BUILD) |-> (rx_valid && rx_cg == line_rx_cg);
  endproperty
  a_rx_line: assert property (p_rx_line) else $error("receive path not fed from line");

  property p_full_stall;
    @(posedge mclk) disable iff (rst)
      (loop_act && !TBI_BUILD && f_full) |-> !tx_ready;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("encoder not stalled when full");

  sequence s_head_waits;
    (loop_act && !TBI_BUILD && f_out_valid && !rx_ready) ##1 (loop_act && !TBI_BUILD);
  endsequence

  property p_rx_hold;
    @(posedge mclk) disable iff (rst)
      s_head_waits |-> $stable(rx_cg);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("looped group changed while stalled");

  property p_cnt_hold;
    @(posedge mclk) disable iff (rst)
      !(f_in_valid && !f_full) |=> $stable(st_r.loop_cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("loop count moved without a push");

  property p_tbi_valid;
    @(posedge mclk) disable iff (rst)
      TBI_BUILD |-> rx_valid;
  endproperty
  a_tbi_valid: assert property (p_tbi_valid) else $error("receive valid low in ten-bit build");
endmodule

/* testbench/plc_xcvr_model.sv */
`timescale 1ns/100ps
module plc_xcvr_model (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Loop controls from the user side
  input  wire logic             wrap,
  input  wire logic [1:0]       loop_sel,
  // Line code groups
  input  wire plc_pkg::plc_cg_t tx_cg,
  output plc_pkg::plc_cg_t      rx_cg
);
  logic [7:0]       far_r;
  plc_pkg::plc_cg_t held_r;
  // Far-end traffic changes every cycle so a stale value never passes for a match.
  always_ff @(posedge mclk) begin
    far_r  <= rst ? 8'h00 : far_r + 8'h01;
    held_r <= tx_cg;
  end
  assign rx_cg = (wrap || loop_sel != 2'h0) ? held_r : {1'b0, far_r};
endmodule

/* testbench/pcs_loopback_control_tb.sv */
`timescale 1ns/100ps
`include "plc_cfg.svh"
module pcs_loopback_control_tb;
  logic             mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic             cfg_loopback = 1'b0, rcs = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  logic [3:0]       avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0]      avs_writedata = 32'h0, avs_readdata;
  logic             avs_waitrequest, tx_ready, rx_valid, wrap_req, wrap_t, rx_valid_t;
  logic [1:0]       loop_sel, loop_sel_t, dbg_sel = 2'h0;
  plc_pkg::plc_cg_t tx_cg = '0, line_tx, line_rx, rx_cg, line_tx_t, line_rx_t, rx_cg_t;
  int               n_errors = 0, checked = 0;
  always #2.5 mclk = ~mclk;
  plc_loopback #(.TBI_BUILD(1'b0)) u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cfg_loopback(cfg_loopback), .receive_clock_source_select(rcs), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_cg(tx_cg), .line_tx_cg(line_tx), .xcvr_loop_sel(loop_sel),
    .line_rx_cg(line_rx), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_cg(rx_cg),
    .wrap_req(wrap_req));
  plc_loopback #(.TBI_BUILD(1'b1)) u_dut_tbi (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(),
    .avs_waitrequest(), .cfg_loopback(cfg_loopback), .receive_clock_source_select(rcs),
    .tx_valid(tx_valid), .tx_ready(), .tx_cg(tx_cg), .line_tx_cg(line_tx_t),
    .xcvr_loop_sel(loop_sel_t), .line_rx_cg(line_rx_t), .rx_valid(rx_valid_t),
    .rx_ready(rx_ready), .rx_cg(rx_cg_t), .wrap_req(wrap_t));
  plc_xcvr_model u_xcvr (.mclk(mclk), .rst(rst), .wrap(wrap_req), .loop_sel(loop_sel | dbg_sel),
    .tx_cg(line_tx), .rx_cg(line_rx));
  plc_xcvr_model u_serdes (.mclk(mclk), .rst(rst), .wrap(wrap_t), .loop_sel(loop_sel_t),
    .tx_cg(line_tx_t), .rx_cg(line_rx_t));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    bus(1'b0, `PLC_ADDR_CTRL, 32'h0, rd);
    chk("ctrl reset", rd, `PLC_CTRL_RST);
    bus(1'b0, 4'hC, 32'h0, rd);
    chk("unmapped", rd, `PLC_BAD_READ);
    chk("loop sel", {28'h0, loop_sel, loop_sel_t}, 32'h0);
    chk("wrap idle", {31'h0, wrap_t}, 32'h0);
    bus(1'b0, `PLC_ADDR_STATUS, 32'h0, rd);
    chk("status reset", rd, 32'h0000_0008);
    avs_byteenable <= 4'hE;
    bus(1'b1, `PLC_ADDR_CTRL, 32'h1, rd);
    avs_byteenable <= 4'hF;
    bus(1'b0, `PLC_ADDR_CTRL, 32'h0, rd);
    chk("lane guard", rd, `PLC_CTRL_RST);
  endtask

  task automatic t_debug_loop();
    dbg_sel  <= 2'h2;
    tx_valid <= 1'b1;
    tx_cg    <= 9'h0A5;
    repeat (3) @(posedge mclk);
    chk("debug loop", {22'h0, rx_valid, rx_cg}, 32'h0000_02A5);
    tx_valid <= 1'b0;
    dbg_sel  <= 2'h0;
    @(posedge mclk);
  endtask

  task automatic t_xcvr_loop();
    logic [31:0]      rd;
    plc_pkg::plc_cg_t g;
    int               k;
    int               j;
    bus(1'b1, `PLC_ADDR_CTRL, 32'h3, rd);
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      g = line_tx;
      @(posedge mclk);
      chk("idle", {23'h0, line_tx}, g.is_k ? 32'h050 : 32'h1BC);
    end
    k = 0;
    tx_valid <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      tx_cg <= {1'b0, 8'h40 + 8'(k)};
      @(posedge mclk);
      if (tx_ready === 1'b1) k++;
    end
    tx_valid <= 1'b0;
    chk("fill count", 32'(k), 32'd16);
    bus(1'b0, `PLC_ADDR_STATUS, 32'h0, rd);
    chk("full", {31'h0, rd[`PLC_ST_FULL_BIT]}, 32'h1);
    bus(1'b0, `PLC_ADDR_CNT, 32'h0, rd);
    chk("looped count", rd, 32'h0000_0010);
    chk("xcvr wrap", {31'h0, wrap_req}, 32'h0);
    j = 0;
    rx_ready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (rx_valid === 1'b1 && j < 16) begin
        chk("looped", {23'h0, rx_cg}, 32'h40 + 32'(j));
        j++;
      end
    end
    chk("drain count", 32'(j), 32'd16);
    bus(1'b0, `PLC_ADDR_STATUS, 32'h0, rd);
    chk("empty active", {30'h0, rd[`PLC_ST_EMPTY_BIT], rd[0]}, 32'h3);
  endtask

  task automatic t_cfg_tbi();
    logic [31:0] rd;
    bus(1'b1, `PLC_ADDR_CTRL, 32'h0, rd);
    repeat (2) @(posedge mclk);
    chk("wrap off", {31'h0, wrap_t}, 32'h0);
    chk("tbi rx", {23'h0, rx_cg_t}, {23'h0, line_rx_t});
    cfg_loopback <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("wrap on", {31'h0, wrap_t}, 32'h1);
    chk("tbi wrapped", {22'h0, rx_valid_t, rx_cg_t}, 32'h0000_0200);
    rcs <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("wrap rclk", {31'h0, wrap_t}, 32'h0);
    bus(1'b0, `PLC_ADDR_STATUS, 32'h0, rd);
    chk("status rclk", {30'h0, rd[`PLC_ST_RCLK_BIT], rd[0]}, 32'h2);
    rcs          <= 1'b0;
    cfg_loopback <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_debug_loop();
    t_xcvr_loop();
    t_cfg_tbi();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    report_and_stop();
  end

  // The whole sequence needs about 130 cycles; this span is ample.
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule
